//--- rtl/rbtc_pkg.sv
// shared constants and carriers of the reading buffer and trigger control block
package rbtc_pkg;

	// register byte offsets
	localparam logic [4:0] ADDR_CTRL   = 5'h00;
	localparam logic [4:0] ADDR_BUFFER_SIZE_SETTING = 5'h04;
	localparam logic [4:0] ADDR_SCOUNT = 5'h08;
	localparam logic [4:0] ADDR_CMD    = 5'h0c;
	localparam logic [4:0] ADDR_STATUS = 5'h10;
	localparam logic [4:0] ADDR_DATA   = 5'h14;
	localparam logic [4:0] ADDR_REMAIN = 5'h18;

	// control register fields
	localparam int CTRL_FEED_LSB = 0;
	localparam int CTRL_FILL_BIT = 2;
	localparam int CTRL_CONT_BIT = 3;
	localparam int CTRL_MATH_LSB = 4;

	// command register bits
	localparam int CMD_INIT_BIT  = 0;
	localparam int CMD_ABORT_BIT = 1;
	localparam int CMD_CLEAR_BIT = 2;
	localparam int CMD_RDBK_BIT  = 3;
	localparam int CMD_SREAD_BIT = 4;
	localparam int CMD_ERRCLR_BIT = 5;

	// status register fields
	localparam int STAT_RUN_BIT   = 0;
	localparam int STAT_STORE_BIT = 1;
	localparam int STAT_FULL_BIT  = 2;
	localparam int STAT_ERR_BIT   = 3;
	localparam int STAT_CNT_LSB   = 4;
	localparam int STAT_SCAN_LSB  = 16;

	// widths and limits
	localparam int PTS_W  = 11;
	localparam int SCNT_W = 14;
	localparam int SCAN_W = 4;
	localparam logic [PTS_W-1:0]  BUFFER_SIZE_SETTING_MIN  = 11'h002;
	localparam logic [PTS_W-1:0]  BUFFER_SIZE_SETTING_MAX  = 11'h400;
	localparam logic [SCNT_W-1:0] SCOUNT_MIN  = 14'h0001;
	localparam logic [SCNT_W-1:0] SCOUNT_MAX  = 14'h270f;

	// values after reset
	localparam logic [PTS_W-1:0]  BUFFER_SIZE_SETTING_RST = 11'h400;
	localparam logic [SCNT_W-1:0] SCOUNT_RST = 14'h0001;

	typedef enum logic [1:0] {
		FEED_NONE = 2'b00,
		FEED_RAW  = 2'b01,
		FEED_CALC = 2'b10
	} rbtc_feed_e;

	typedef enum logic [1:0] {
		MATH_OFF    = 2'b00,
		MATH_OFFSET = 2'b01,
		MATH_PCT    = 2'b10
	} rbtc_math_e;

	typedef enum logic {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} rbtc_state_e;

	// one finished measurement with its math results
	typedef struct packed {
		logic        valid;
		logic [31:0] raw;
		logic [31:0] offset_scale_math;
		logic [31:0] math_a;
	} rbtc_meas_s;

	// avalon-mm slave request
	typedef struct packed {
		logic        read;
		logic        write;
		logic [4:0]  address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} rbtc_avm_req_s;

endpackage

//--- rtl/rbtc_store.sv
// reading buffer memory with write and readback pointers
`timescale 1ns/10ps
`default_nettype none

module rbtc_store #(
	parameter int DEPTH = 1024,
	parameter int WIDTH = 32
) (
	input  wire logic                     ref_clk,
	input  wire logic                     sys_rst,
	input  wire logic                     wr_en,
	input  wire logic [WIDTH-1:0]         wr_data,
	input  wire logic                     wr_restart,
	input  wire logic                     rd_restart,
	input  wire logic                     rd_adv,
	output logic      [$clog2(DEPTH):0]   count,
	output logic      [$clog2(DEPTH):0]   rd_left,
	output logic      [WIDTH-1:0]         rd_data
);
	localparam int AW = $clog2(DEPTH);

	// refused at elaboration so a bad size fill_policy_off reaches simulation
	if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
		$error("rbtc_store: unsupported DEPTH or WIDTH");
	end

	typedef struct packed {
		logic [AW:0] wr_ptr;
		logic [AW:0] rd_ptr;
	} rbtc_store_s;

	rbtc_store_s       s_q;
	rbtc_store_s       s_d;
	logic [WIDTH-1:0]  mem [DEPTH];

	////////////////////////////////////////////////////////////////
	always_comb begin
		s_d = s_q;
		if (wr_restart) begin
			s_d.wr_ptr = '0;
		end else if (wr_en && s_q.wr_ptr < (AW+1)'(DEPTH)) begin
			s_d.wr_ptr = s_q.wr_ptr + (AW+1)'(1);
		end
		if (rd_restart || wr_restart) begin
			s_d.rd_ptr = '0;
		end else if (rd_adv && s_q.rd_ptr < s_q.wr_ptr) begin
			s_d.rd_ptr = s_q.rd_ptr + (AW+1)'(1);
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// memory holds no reset: contents beyond count are don't-care
	always_ff @(posedge ref_clk) begin
		if (wr_en && !wr_restart && s_q.wr_ptr < (AW+1)'(DEPTH)) begin
			mem[s_q.wr_ptr[AW-1:0]] <= wr_data;
		end
	end

	////////////////////////////////////////////////////////////////
	assign count   = s_q.wr_ptr;
	assign rd_left = s_q.wr_ptr - s_q.rd_ptr;
	// asynchronous read so a pop is seen by the very next request
	assign rd_data = (s_q.rd_ptr < s_q.wr_ptr) ? mem[s_q.rd_ptr[AW-1:0]] : '0;

endmodule

`default_nettype wire

//--- rtl/rbtc_ctrl.sv
// reading buffer feed control and initiate/abort trigger control with avalon-mm registers
`timescale 1ns/10ps
`default_nettype none

module rbtc_ctrl #(
	parameter int DEPTH    = 1024,
	parameter int SCAN_LEN = 10
) (
	input  wire logic                         ref_clk,
	input  wire logic                         sys_rst,
	input  wire rbtc_pkg::rbtc_avm_req_s      avm_req,
	output logic      [31:0]                  avm_readdata,
	output logic                              avm_waitrequest,
	input  wire rbtc_pkg::rbtc_meas_s         meas,
	output logic                              trig_armed,
	output logic                              storing,
	output logic      [rbtc_pkg::SCAN_W-1:0]  scan_ptr
);
	localparam int CW = $clog2(DEPTH) + 1;

	// refused at elaboration: the point limits and scan width are fixed
	if (DEPTH != 32'(rbtc_pkg::BUFFER_SIZE_SETTING_MAX) || SCAN_LEN < 1 ||
	    SCAN_LEN > (1 << rbtc_pkg::SCAN_W)) begin : g_bad_param
		$error("rbtc_ctrl: DEPTH or SCAN_LEN outside supported range");
	end

	typedef struct packed {
		logic                          wait_n;
		logic [31:0]                   rdata;
		rbtc_pkg::rbtc_feed_e          feed;
		logic                          fill_once;
		logic                          cont;
		rbtc_pkg::rbtc_math_e          math;
		logic [rbtc_pkg::PTS_W-1:0]    buffer_size_setting;
		logic [rbtc_pkg::SCNT_W-1:0]   scount;
		rbtc_pkg::rbtc_state_e         st;
		logic [rbtc_pkg::SCNT_W-1:0]   actions;
		logic                          storing;
		logic                          full;
		logic                          err;
		logic [rbtc_pkg::SCAN_W-1:0]   scan;
	} rbtc_ctrl_s;

	rbtc_ctrl_s       c_q;
	rbtc_ctrl_s       c_d;
	logic [CW-1:0]    st_count;
	logic [CW-1:0]    st_left;
	logic [31:0]      st_rdata;
	logic             st_wr_en;
	logic [31:0]      st_wr_data;
	logic             st_wr_restart;
	logic             st_rd_restart;
	logic             st_rd_adv;

	////////////////////////////////////////////////////////////////
	// byte-lane merge of a write into the old register image
	function automatic logic [31:0] merge_be(input logic [31:0] old_v,
	                                         input logic [31:0] new_v,
	                                         input logic [3:0]  be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] ctrl_image(input rbtc_ctrl_s c);
		logic [31:0] r;
		r = '0;
		r[rbtc_pkg::CTRL_FEED_LSB +: 2] = c.feed;
		r[rbtc_pkg::CTRL_FILL_BIT]      = c.fill_once;
		r[rbtc_pkg::CTRL_CONT_BIT]      = c.cont;
		r[rbtc_pkg::CTRL_MATH_LSB +: 2] = c.math;
		return r;
	endfunction

	////////////////////////////////////////////////////////////////
	// bus request decode
	logic        acc;
	logic        wr_acc;
	logic        rd_acc;
	logic [31:0] wv;
	logic [31:0] cur_img;
	logic        meas_take;
	logic        store_now;
	logic [31:0] calc_val;

	always_comb begin
		// request is accepted at the edge where waitrequest is seen low
		acc    = (avm_req.read || avm_req.write) && !c_q.wait_n;
		wr_acc = acc && avm_req.write;
		rd_acc = acc && avm_req.read;
		case (avm_req.address)
			rbtc_pkg::ADDR_CTRL:   cur_img = ctrl_image(c_q);
			rbtc_pkg::ADDR_BUFFER_SIZE_SETTING: cur_img = 32'(c_q.buffer_size_setting);
			rbtc_pkg::ADDR_SCOUNT: cur_img = 32'(c_q.scount);
			default:               cur_img = '0;
		endcase
		wv = merge_be(cur_img, avm_req.writedata, avm_req.byteenable);
	end

	// calculated value follows the math mode
	always_comb begin
		case (c_q.math)
			rbtc_pkg::MATH_OFFSET: calc_val = meas.offset_scale_math;
			rbtc_pkg::MATH_PCT:    calc_val = meas.math_a;
			default:               calc_val = meas.raw;
		endcase
	end

	always_comb begin
		meas_take  = meas.valid && c_q.st == rbtc_pkg::ST_RUN;
		store_now  = meas_take && c_q.storing && c_q.fill_once &&
		             c_q.feed != rbtc_pkg::FEED_NONE;
		st_wr_en   = store_now;
		st_wr_data = (c_q.feed == rbtc_pkg::FEED_CALC) ? calc_val : meas.raw;
	end

	////////////////////////////////////////////////////////////////
	// next state
	logic [31:0] stat_img;
	logic        abort_cmd;
	logic        init_cmd;
	logic        sread_cmd;

	always_comb begin
		c_d           = c_q;
		st_wr_restart = 1'b0;
		st_rd_restart = 1'b0;
		st_rd_adv     = 1'b0;
		abort_cmd     = 1'b0;
		init_cmd      = 1'b0;
		sread_cmd     = 1'b0;

		stat_img = '0;
		stat_img[rbtc_pkg::STAT_RUN_BIT]             = c_q.st == rbtc_pkg::ST_RUN;
		stat_img[rbtc_pkg::STAT_STORE_BIT]           = c_q.storing;
		stat_img[rbtc_pkg::STAT_FULL_BIT]            = c_q.full;
		stat_img[rbtc_pkg::STAT_ERR_BIT]             = c_q.err;
		stat_img[rbtc_pkg::STAT_CNT_LSB +: CW]       = st_count;
		stat_img[rbtc_pkg::STAT_SCAN_LSB +: rbtc_pkg::SCAN_W] = c_q.scan;

		// one wait cycle, then answer for exactly one cycle
		c_d.wait_n = !((avm_req.read || avm_req.write) && c_q.wait_n);
		c_d.rdata  = '0;
		if ((avm_req.read || avm_req.write) && c_q.wait_n && avm_req.read) begin
			case (avm_req.address)
				rbtc_pkg::ADDR_CTRL:   c_d.rdata = ctrl_image(c_q);
				rbtc_pkg::ADDR_BUFFER_SIZE_SETTING: c_d.rdata = 32'(c_q.buffer_size_setting);
				rbtc_pkg::ADDR_SCOUNT: c_d.rdata = 32'(c_q.scount);
				rbtc_pkg::ADDR_STATUS: c_d.rdata = stat_img;
				rbtc_pkg::ADDR_DATA:   c_d.rdata = st_rdata;
				rbtc_pkg::ADDR_REMAIN: c_d.rdata = 32'(st_left);
				default:               c_d.rdata = '0;
			endcase
		end
		if (rd_acc && avm_req.address == rbtc_pkg::ADDR_DATA) begin
			st_rd_adv = 1'b1;
		end

		// trigger sequence: each accepted measurement is one device action
		if (meas_take) begin
			c_d.scan = (c_q.scan == rbtc_pkg::SCAN_W'(SCAN_LEN - 1)) ? '0 :
			           c_q.scan + rbtc_pkg::SCAN_W'(1);
			if (c_q.actions + rbtc_pkg::SCNT_W'(1) >= c_q.scount) begin
				c_d.actions = '0;
				c_d.st      = c_q.cont ? rbtc_pkg::ST_RUN : rbtc_pkg::ST_IDLE;
			end else begin
				c_d.actions = c_q.actions + rbtc_pkg::SCNT_W'(1);
			end
		end

		// fill-once completion
		if (store_now && st_count + CW'(1) >= CW'(c_q.buffer_size_setting)) begin
			c_d.storing = 1'b0;
			c_d.full    = 1'b1;
		end

		if (wr_acc) begin
			case (avm_req.address)
				rbtc_pkg::ADDR_CTRL: begin
					c_d.feed = rbtc_pkg::rbtc_feed_e'(wv[rbtc_pkg::CTRL_FEED_LSB +: 2]);
					c_d.math = rbtc_pkg::rbtc_math_e'(wv[rbtc_pkg::CTRL_MATH_LSB +: 2]);
					c_d.cont = wv[rbtc_pkg::CTRL_CONT_BIT];
					c_d.fill_once = wv[rbtc_pkg::CTRL_FILL_BIT];
					if (wv[rbtc_pkg::CTRL_FILL_BIT] && !c_q.fill_once) begin
						// new fill-once operation starts from location zero
						c_d.storing   = 1'b1;
						c_d.full      = 1'b0;
						st_wr_restart = 1'b1;
					end else if (!wv[rbtc_pkg::CTRL_FILL_BIT]) begin
						c_d.storing = 1'b0;
					end
					if (wv[rbtc_pkg::CTRL_CONT_BIT]) begin
						c_d.st = rbtc_pkg::ST_RUN;
					end
				end
				rbtc_pkg::ADDR_BUFFER_SIZE_SETTING: begin
					if (wv[31:rbtc_pkg::PTS_W] == '0 &&
					    wv[rbtc_pkg::PTS_W-1:0] >= rbtc_pkg::BUFFER_SIZE_SETTING_MIN &&
					    wv[rbtc_pkg::PTS_W-1:0] <= rbtc_pkg::BUFFER_SIZE_SETTING_MAX) begin
						c_d.buffer_size_setting = wv[rbtc_pkg::PTS_W-1:0];
					end else begin
						c_d.err = 1'b1;
					end
				end
				rbtc_pkg::ADDR_SCOUNT: begin
					if (wv[31:rbtc_pkg::SCNT_W] != '0 ||
					    wv[rbtc_pkg::SCNT_W-1:0] < rbtc_pkg::SCOUNT_MIN ||
					    wv[rbtc_pkg::SCNT_W-1:0] > rbtc_pkg::SCOUNT_MAX ||
					    (c_q.cont && wv[rbtc_pkg::SCNT_W-1:0] > rbtc_pkg::SCOUNT_MIN)) begin
						c_d.err = 1'b1;
					end else begin
						c_d.scount = wv[rbtc_pkg::SCNT_W-1:0];
					end
				end
				rbtc_pkg::ADDR_CMD: begin
					init_cmd  = avm_req.byteenable[0] && wv[rbtc_pkg::CMD_INIT_BIT];
					abort_cmd = avm_req.byteenable[0] && wv[rbtc_pkg::CMD_ABORT_BIT];
					sread_cmd = avm_req.byteenable[0] && wv[rbtc_pkg::CMD_SREAD_BIT];
					if (avm_req.byteenable[0] && wv[rbtc_pkg::CMD_CLEAR_BIT]) begin
						st_wr_restart = 1'b1;
						c_d.full      = 1'b0;
						c_d.storing   = c_q.fill_once;
					end
					if (avm_req.byteenable[0] && wv[rbtc_pkg::CMD_RDBK_BIT]) begin
						st_rd_restart = 1'b1;
					end
					if (avm_req.byteenable[0] && wv[rbtc_pkg::CMD_ERRCLR_BIT]) begin
						c_d.err = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end

		if (init_cmd && c_q.st == rbtc_pkg::ST_IDLE) begin
			c_d.st      = rbtc_pkg::ST_RUN;
			c_d.actions = '0;
		end
		if (sread_cmd) begin
			if (c_q.cont) begin
				c_d.err = 1'b1;
			end else if (c_q.st == rbtc_pkg::ST_IDLE) begin
				c_d.st      = rbtc_pkg::ST_RUN;
				c_d.actions = '0;
			end
		end
		// abort wins over everything else in the sequence
		if (abort_cmd) begin
			c_d.actions = '0;
			c_d.scan    = '0;
			c_d.st      = c_q.cont ? rbtc_pkg::ST_RUN : rbtc_pkg::ST_IDLE;
		end
		// a refusal in the same cycle as an error clear keeps the error
		if (wr_acc && avm_req.address == rbtc_pkg::ADDR_CMD && c_d.err == 1'b0 &&
		    ((sread_cmd && c_q.cont))) begin
			c_d.err = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			c_q           <= '0;
			c_q.wait_n    <= 1'b1;
			c_q.feed      <= rbtc_pkg::FEED_RAW;
			c_q.math      <= rbtc_pkg::MATH_OFF;
			c_q.buffer_size_setting    <= rbtc_pkg::BUFFER_SIZE_SETTING_RST;
			c_q.scount    <= rbtc_pkg::SCOUNT_RST;
			c_q.st        <= rbtc_pkg::ST_IDLE;
		end else begin
			c_q <= c_d;
		end
	end

	////////////////////////////////////////////////////////////////
	rbtc_store #(
		.DEPTH (DEPTH),
		.WIDTH (32)
	) u_store (
		.ref_clk    (ref_clk),
		.sys_rst    (sys_rst),
		.wr_en      (st_wr_en),
		.wr_data    (st_wr_data),
		.wr_restart (st_wr_restart),
		.rd_restart (st_rd_restart),
		.rd_adv     (st_rd_adv),
		.count      (st_count),
		.rd_left    (st_left),
		.rd_data    (st_rdata)
	);

	assign avm_readdata    = c_q.rdata;
	assign avm_waitrequest = c_q.wait_n;
	assign trig_armed      = c_q.st == rbtc_pkg::ST_RUN;
	assign storing         = c_q.storing;
	assign scan_ptr        = c_q.scan;

endmodule

`default_nettype wire

//--- dv/rbtc_ctrl_sva.sv
// concurrent checks on the ports of the reading buffer trigger control block
`timescale 1ns/10ps
`default_nettype none

module rbtc_ctrl_sva #(
	parameter int DEPTH    = 1024,
	parameter int SCAN_LEN = 10
) (
	input  wire logic                          ref_clk,
	input  wire logic                          sys_rst,
	input  wire rbtc_pkg::rbtc_avm_req_s       avm_req,
	input  wire logic      [31:0]              avm_readdata,
	input  wire logic                          avm_waitrequest,
	input  wire rbtc_pkg::rbtc_meas_s          meas,
	input  wire logic                          trig_armed,
	input  wire logic                          storing,
	input  wire logic      [rbtc_pkg::SCAN_W-1:0] scan_ptr
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	logic                        wr_ok;
	logic                        ctl_wr;
	logic                        cmd_wr;
	logic                        cont_q;
	logic                        fill_q;
	logic [rbtc_pkg::SCAN_W-1:0] scan_nx;

	assign wr_ok  = avm_req.write && !avm_waitrequest;
	assign ctl_wr = wr_ok && avm_req.address == rbtc_pkg::ADDR_CTRL && avm_req.byteenable[0];
	assign cmd_wr = wr_ok && avm_req.address == rbtc_pkg::ADDR_CMD && avm_req.byteenable[0];
	assign scan_nx = (int'(scan_ptr) == SCAN_LEN - 1) ? '0 : scan_ptr + 4'h1;

	// shadow of the control bits, only accepted writes count
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cont_q <= 1'b0;
			fill_q <= 1'b0;
		end else if (ctl_wr) begin
			cont_q <= avm_req.writedata[3];
			fill_q <= avm_req.writedata[2];
		end
	end

	////////////////////////////////////////////////////////////////////////
	sequence s_req_wait;
		(avm_req.read || avm_req.write) && avm_waitrequest;
	endsequence
	sequence s_answer;
		!avm_waitrequest ##1 avm_waitrequest;
	endsequence

	a_wait_answer: assert property (s_req_wait |=> s_answer)
		else $error("bus answer not a single cycle");
	a_read_zero: assert property (avm_waitrequest |-> avm_readdata == 32'h0)
		else $error("read data not zero at rest");
	a_init_arms: assert property (cmd_wr && avm_req.writedata[0] && !avm_req.writedata[1] |=> trig_armed)
		else $error("initiate did not leave idle");
	a_abort_top: assert property (cmd_wr && avm_req.writedata[1] |=> scan_ptr == '0 && trig_armed == cont_q)
		else $error("abort did not return to top");
	a_cont_arms: assert property (ctl_wr && avm_req.writedata[3] |=> trig_armed)
		else $error("continuous did not leave idle");
	a_scan_step: assert property (meas.valid && trig_armed && !cmd_wr |=> scan_ptr == $past(scan_nx))
		else $error("scan pointer did not step");
	a_idle_hold: assert property (!trig_armed && !wr_ok |=> $stable(scan_ptr))
		else $error("scan pointer moved while idle");
	a_fill_off: assert property (!fill_q |-> !storing)
		else $error("storing with fill policy off");
endmodule

bind rbtc_ctrl rbtc_ctrl_sva #(.DEPTH(DEPTH), .SCAN_LEN(SCAN_LEN)) u_sva (
	.ref_clk(ref_clk), .sys_rst(sys_rst), .avm_req(avm_req),
	.avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .meas(meas),
	.trig_armed(trig_armed), .storing(storing), .scan_ptr(scan_ptr));
`default_nettype wire

//--- dv/rbtc_meas_src.sv
// measurement source standing in for the converter and math stage
`timescale 1ns/10ps
`default_nettype none

module rbtc_meas_src (
	input  wire logic                 ref_clk,
	input  wire logic                 sys_rst,
	input  wire logic                 fire,
	input  wire logic [31:0]          val,
	output var  rbtc_pkg::rbtc_meas_s meas
);
	logic [31:0] x;

	// between pulses the data lines toggle so stale values fill_policy_off look valid
	assign x = fire ? val : ~meas.raw;

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			meas <= '0;
		end else begin
			meas.valid             <= fire;
			meas.raw               <= x;
			meas.offset_scale_math <= x ^ 32'h00ff00ff;
			meas.math_a            <= x + 32'h1;
		end
	end
endmodule
`default_nettype wire

//--- dv/tb.sv
// self-checking bench of the reading buffer trigger control block
`timescale 1ns/10ps
`default_nettype none

module tb;
	logic                    ref_clk;
	logic                    sys_rst;
	logic                    fire;
	logic                    trig_armed;
	logic                    storing;
	logic                    avm_waitrequest;
	logic [31:0]             val;
	logic [31:0]             avm_readdata;
	logic [31:0]             q;
	logic [3:0]              scan_ptr;
	logic [5:0]              ctl;
	logic [31:0]             v [3];
	rbtc_pkg::rbtc_avm_req_s avm;
	rbtc_pkg::rbtc_meas_s    meas;
	int                      err_count;
	int                      comparisons;
	int                      k;
	int                      m;
	int                      n;
	int                      sp;
	// feed, fill, continuous and math per run
	logic [5:0] tab [6] = '{6'h05, 6'h06, 6'h16, 6'h26, 6'h04, 6'h01};

	rbtc_ctrl #(.DEPTH(1024), .SCAN_LEN(10)) uut (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .avm_req(avm), .avm_readdata(avm_readdata),
		.avm_waitrequest(avm_waitrequest), .meas(meas), .trig_armed(trig_armed),
		.storing(storing), .scan_ptr(scan_ptr));
	rbtc_meas_src src (.ref_clk(ref_clk), .sys_rst(sys_rst), .fire(fire), .val(val), .meas(meas));

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic conclude;
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask

	// request held until waitrequest is seen low at a rising edge
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int c;
		@(posedge ref_clk);
		avm.read <= !w;
		avm.write <= w;
		avm.address <= a;
		avm.writedata <= d;
		avm.byteenable <= 4'hf;
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (avm_waitrequest !== 1'b0 && c < 20);
		q = avm_readdata;
		avm.read <= 1'b0;
		avm.write <= 1'b0;
		if (avm_waitrequest !== 1'b0) begin
			err_count++;
			conclude();
		end
	endtask

	task automatic rd(input logic [4:0] a, input string nm, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask

	task automatic pulse(input logic [31:0] x);
		@(posedge ref_clk);
		fire <= 1'b1;
		val <= x;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (2) @(posedge ref_clk);
		sp = (sp + 1) % 10;
	endtask

	function automatic logic [31:0] expv(input logic [5:0] c, input logic [31:0] x);
		if (c[1:0] == 2'h2 && c[5:4] == 2'h1)
			return x ^ 32'h00ff00ff;
		if (c[1:0] == 2'h2 && c[5:4] == 2'h2)
			return x + 32'h1;
		return x;
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		sys_rst = 1'b1;
		fire = 1'b0;
		val = 32'h0;
		avm = '0;
		err_count = 0;
		comparisons = 0;
		sp = 0;
		void'($urandom(32'h4d42));
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		rd(rbtc_pkg::ADDR_CTRL, "ctrl", 32'h1);
		rd(rbtc_pkg::ADDR_BUFFER_SIZE_SETTING, "buffer_size_setting", 32'h400);
		rd(rbtc_pkg::ADDR_SCOUNT, "scount", 32'h1);
		rd(rbtc_pkg::ADDR_CMD, "cmd", 32'h0);
		rd(5'h1c, "unmapped", 32'h0);
		// smallest buffer, one extra reading per run must be dropped
		bus(1'b1, rbtc_pkg::ADDR_BUFFER_SIZE_SETTING, 32'h2);
		bus(1'b1, rbtc_pkg::ADDR_SCOUNT, 32'h3);
		for (m = 0; m < 6; m++) begin
			ctl = tab[m];
			bus(1'b1, rbtc_pkg::ADDR_CTRL, 32'h0);
			bus(1'b1, rbtc_pkg::ADDR_CTRL, {26'h0, ctl});
			bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h1);
			@(negedge ref_clk);
			chk("armed", trig_armed, 1'b1);
			for (k = 0; k < 3; k++) begin
				v[k] = $urandom;
				pulse(v[k]);
			end
			chk("idle", trig_armed, 1'b0);
			// feed none with fill-once fill_policy_off fills, so storage stays pending
			chk("storing", storing, ctl[2] && ctl[1:0] == 2'h0);
			n = (ctl[1:0] != 2'h0 && ctl[2]) ? 2 : 0;
			rd(rbtc_pkg::ADDR_REMAIN, "remain", n);
			for (k = 0; k < n; k++)
				rd(rbtc_pkg::ADDR_DATA, "data", expv(ctl, v[k]));
			rd(rbtc_pkg::ADDR_DATA, "drained", 32'h0);
			bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h8);
			rd(rbtc_pkg::ADDR_REMAIN, "reread", n);
			bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h4);
			rd(rbtc_pkg::ADDR_REMAIN, "cleared", 32'h0);
		end
		bus(1'b1, rbtc_pkg::ADDR_BUFFER_SIZE_SETTING, 32'h1);
		bus(1'b1, rbtc_pkg::ADDR_BUFFER_SIZE_SETTING, 32'h401);
		rd(rbtc_pkg::ADDR_BUFFER_SIZE_SETTING, "buffer_size_setting", 32'h2);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h20);
		bus(1'b1, rbtc_pkg::ADDR_SCOUNT, 32'h1);
		bus(1'b1, rbtc_pkg::ADDR_CTRL, 32'h9);
		@(negedge ref_clk);
		chk("cont armed", trig_armed, 1'b1);
		rd(rbtc_pkg::ADDR_CTRL, "ctrl", 32'h9);
		bus(1'b1, rbtc_pkg::ADDR_SCOUNT, 32'h2);
		rd(rbtc_pkg::ADDR_SCOUNT, "scount", 32'h1);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h20);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h10);
		bus(1'b0, rbtc_pkg::ADDR_STATUS, 32'h0);
		chk("err", q[3], 1'b1);
		m = 1 + $urandom % 5;
		for (k = 0; k < m; k++)
			pulse($urandom);
		chk("restart", trig_armed, 1'b1);
		chk("scan", scan_ptr, sp);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h2);
		@(negedge ref_clk);
		chk("scan top", scan_ptr, 32'h0);
		chk("resume", trig_armed, 1'b1);
		bus(1'b1, rbtc_pkg::ADDR_CTRL, 32'h1);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h2);
		@(negedge ref_clk);
		chk("abort idle", trig_armed, 1'b0);
		bus(1'b1, rbtc_pkg::ADDR_CMD, 32'h10);
		@(negedge ref_clk);
		chk("single read", trig_armed, 1'b1);
		conclude();
	end
endmodule
`default_nettype wire
